// ===== rtl/adcc_ctrl.sv
// Purpose: Control/status and result registers of a 10-bit SAR converter, with its sequencer
// Assumes: mclk is the CPU clock; comparator answers in the same converter tick
// Notes: One-cycle APB answer; no interrupt output; continuous conversion while on
`timescale 1ns/1ps
module adcc_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire adcc_pkg::adcc_apb_req_t apb_req,
  output adcc_pkg::adcc_apb_rsp_t apb_rsp,
  input wire logic halt_mode,
  input wire logic cmp_above,
  output logic [3:0] channel_select,
  output logic channel_reserved,
  output logic converter_on,
  output logic sample_hold,
  output logic [9:0] dac_code
);
  import adcc_pkg::*;

  adcc_state_t s_q;
  adcc_state_t s_d;
  logic [ADCC_ADDR_W-3:0] widx;
  logic acc;
  logic wr_csr;
  logic rd_high;
  logic tick;
  logic [1:0] div_top;
  logic restart;
  logic [9:0] trial;
  logic [7:0] csr_val;

  assign widx = apb_req.paddr[ADCC_ADDR_W-1:2];
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_csr = acc && apb_req.pwrite && widx == 10'(ADCC_IDX_CSR);
  assign rd_high = acc && !apb_req.pwrite && widx == 10'(ADCC_IDX_RESH);
  // Speed bit selects the converter tick rate from the CPU clock
  assign div_top = s_q.speed ? 2'(ADCC_DIV_FAST - 1) : 2'(ADCC_DIV_SLOW - 1);
  assign tick = s_q.div == div_top;
  assign trial = s_q.sar | (10'h001 << (4'(ADCC_RES_BITS - 1) - s_q.step));
  assign csr_val = {s_q.done, s_q.speed, s_q.on, 1'b0, s_q.chan};
  // Any status write restarts; a new channel also aborts the running conversion
  assign restart = wr_csr;

  always_comb begin
    s_d = s_q;
    s_d.div = tick ? ADCC_DIV_RST : s_q.div + 2'h1;
    if (wr_csr) begin
      s_d.speed = apb_req.pwdata[ADCC_BIT_SPEED];
      s_d.on = apb_req.pwdata[ADCC_BIT_ON];
      s_d.chan = apb_req.pwdata[3:0];
    end
    if (halt_mode) begin
      s_d.on = 1'b0;
    end
    // Sequencer: sample, then ten compare steps, then loop
    if (!s_d.on || restart) begin
      s_d.phase = s_d.on ? ADCC_SAMPLE : ADCC_IDLE;
      s_d.step = ADCC_STEP_RST;
      s_d.sar = ADCC_RES_RST;
      s_d.div = ADCC_DIV_RST;
    end else if (tick) begin
      unique case (s_q.phase)
        ADCC_IDLE: begin
          s_d.phase = ADCC_SAMPLE;
          s_d.step = ADCC_STEP_RST;
        end
        ADCC_SAMPLE: begin
          s_d.step = s_q.step + 4'h1;
          if (s_q.step == 4'(ADCC_SAMPLE_TICKS - 1)) begin
            s_d.phase = ADCC_CONVERT;
            s_d.step = ADCC_STEP_RST;
          end
        end
        ADCC_CONVERT: begin
          s_d.sar = cmp_above ? trial : s_q.sar;
          s_d.step = s_q.step + 4'h1;
          if (s_q.step == 4'(ADCC_RES_BITS - 1)) begin
            // Result lands only with all ten bits decided
            s_d.result = cmp_above ? trial : s_q.sar;
            s_d.sar = ADCC_RES_RST;
            s_d.step = ADCC_STEP_RST;
            s_d.phase = ADCC_SAMPLE;
          end
        end
      endcase
    end
    // Set wins over an upper-result read clear in the same cycle; a status write blocks the set
    if (rd_high || wr_csr) begin
      s_d.done = 1'b0;
    end
    if (s_q.on && !restart && tick && s_q.phase == ADCC_CONVERT &&
        s_q.step == 4'(ADCC_RES_BITS - 1) && s_d.on) begin
      s_d.done = 1'b1;
    end
    s_d.prdata = '0;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      if (widx == 10'(ADCC_IDX_CSR)) begin
        s_d.prdata = {24'h0, csr_val};
      end else if (widx == 10'(ADCC_IDX_RESH)) begin
        s_d.prdata = {24'h0, s_q.result[9:2]};
      end else if (widx == 10'(ADCC_IDX_RESL)) begin
        s_d.prdata = {24'h0, 6'h00, s_q.result[1:0]};
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{done: 1'b0, speed: 1'b0, on: 1'b0, chan: 4'h0, result: ADCC_RES_RST, sar: ADCC_RES_RST,
               phase: ADCC_IDLE, step: ADCC_STEP_RST, div: ADCC_DIV_RST, prdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Unmapped words read zero; no error so legacy code probing gaps does not fault
  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign channel_select = s_q.chan;
  // Reserved codes still convert whatever the mux presents; flagged for the mux
  assign channel_reserved = (s_q.chan == 4'h6) || (s_q.chan == 4'h7) ||
                            (s_q.chan == 4'h9) || (s_q.chan == 4'hB);
  assign converter_on = s_q.on;
  assign sample_hold = s_q.phase == ADCC_SAMPLE;
  assign dac_code = s_q.phase == ADCC_CONVERT ? trial : ADCC_RES_RST;

  // Done flag: set by the sequencer, cleared only by software access
  done_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(s_q.done) |-> $past(s_q.phase) == ADCC_CONVERT && $past(s_q.step) == 4'h9)
    else $error("done flag rose outside the last compare step");

  done_tick_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(s_q.done) |-> $past(tick) && $past(converter_on))
    else $error("done flag rose without a converter tick");

  done_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.done && !rd_high && !wr_csr |=> s_q.done)
    else $error("done flag dropped without a software access");

  done_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_high && !(tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9) |=> !s_q.done)
    else $error("upper result read left the done flag set");

  wr_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr |=> !s_q.done)
    else $error("status write left the done flag set");

  // Converter tick rate
  div_rate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && !s_q.speed && !wr_csr |=> !tick ##1 !tick ##1 !tick)
    else $error("slow tick came sooner than every fourth clock");

  div_fast_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && s_q.speed && !wr_csr |=> !tick)
    else $error("fast tick came on two clocks in a row");

  div_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.div <= div_top)
    else $error("divider count ran past its terminal value");

  tick_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !converter_on |-> !tick)
    else $error("converter tick while the converter is off");

  speed_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr |=> s_q.speed == $past(apb_req.pwdata[6]))
    else $error("speed bit did not take the written value");

  speed_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !wr_csr |=> $stable(s_q.speed))
    else $error("speed bit changed without a status write");

  // On bit and sequencer
  off_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr && !apb_req.pwdata[5] |=> s_q.phase == ADCC_IDLE && !converter_on)
    else $error("clearing the on bit did not stop the sequencer");

  on_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr && !halt_mode |=> converter_on == $past(apb_req.pwdata[5]))
    else $error("on bit did not take the written value");

  on_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !wr_csr && !halt_mode |=> $stable(converter_on))
    else $error("on bit changed without a write or halt");

  off_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !converter_on |-> s_q.phase == ADCC_IDLE && !sample_hold && dac_code == 10'h000)
    else $error("sequencer active while the converter is off");

  idle_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.phase == ADCC_IDLE |-> !converter_on)
    else $error("converter on but sequencer idle");

  loop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9 &&
      converter_on && !wr_csr && !halt_mode |=> sample_hold)
    else $error("no new sample after a finished conversion");

  sar_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9 &&
      converter_on && !wr_csr && !halt_mode |=> s_q.sar == 10'h000 && s_q.step == 4'h0)
    else $error("approximation register not cleared for the next conversion");

  set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9 &&
      converter_on && !wr_csr && !halt_mode |=> s_q.done)
    else $error("finished conversion did not set the done flag");

  result_land_a: assert property (@(posedge mclk) disable iff (sys_rst)
    tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9 && converter_on && !wr_csr && !halt_mode |=>
      s_q.result == ($past(cmp_above) ? $past(dac_code) : $past(s_q.sar)))
    else $error("result does not hold the last decided code");

  seq_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(s_q.phase == ADCC_CONVERT) |-> $past(s_q.phase) == ADCC_SAMPLE)
    else $error("compare phase entered without sampling");

  conv_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(s_q.phase == ADCC_CONVERT) |-> $past(s_q.step) == 4'h1 && $past(tick))
    else $error("compare phase entered before two sample ticks");

  restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr && apb_req.pwdata[5] && !halt_mode |=> sample_hold && !s_q.done)
    else $error("status write did not restart the conversion");

  abort_sar_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr |=> s_q.sar == 10'h000 && s_q.step == 4'h0)
    else $error("status write did not abort the running conversion");

  // Channel select
  chan_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_csr |=> channel_select == $past(apb_req.pwdata[3:0]))
    else $error("channel field did not take the written value");

  chan_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !wr_csr |=> $stable(channel_select))
    else $error("channel field changed without a status write");

  reserved_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    channel_reserved == ((!channel_select[3] && channel_select[2:1] == 2'b11) ||
      (channel_select[3] && !channel_select[2] && channel_select[0])))
    else $error("reserved channel flag wrong for the selected code");

  // Register reads
  csr_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && widx == 10'h070 |=>
      apb_rsp.prdata == {24'h0, $past(s_q.done), $past(s_q.speed), $past(converter_on), 1'b0,
                         $past(channel_select)})
    else $error("status register read returned wrong fields");

  csr_upper_a: assert property (@(posedge mclk) disable iff (sys_rst)
    acc && !apb_req.pwrite && widx == 10'h070 |-> apb_rsp.prdata[31:8] == 24'h0 && !apb_rsp.prdata[4])
    else $error("status read shows bits that must read zero");

  high_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && widx == 10'h071 |=>
      apb_rsp.prdata == {24'h0, $past(s_q.result[9:2])})
    else $error("upper result read returned wrong bits");

  high_upper_a: assert property (@(posedge mclk) disable iff (sys_rst)
    acc && !apb_req.pwrite && widx == 10'h071 |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper result read shows bits above the byte");

  low_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    acc && widx == 10'h072 |-> apb_rsp.prdata[31:2] == 30'h0)
    else $error("lower result read shows forced-zero bits set");

  low_bits_a: assert property (@(posedge mclk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && widx == 10'h072 |=>
      apb_rsp.prdata[1:0] == $past(s_q.result[1:0]))
    else $error("lower result read returned wrong low bits");

  unmapped_a: assert property (@(posedge mclk) disable iff (sys_rst)
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && widx != 10'h070 && widx != 10'h071 &&
      widx != 10'h072 |=> apb_rsp.prdata == 32'h0)
    else $error("unmapped word read returned non-zero data");

  ignore_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    acc && apb_req.pwrite && widx != 10'h070 && !halt_mode |=>
      $stable(channel_select) && $stable(converter_on) && $stable(s_q.speed))
    else $error("write to a read-only word changed the status register");

  idle_prdata_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(apb_req.psel && !apb_req.penable) |=> apb_rsp.prdata == 32'h0)
    else $error("read data left standing outside an access");

  ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
    apb_rsp.pready && !apb_rsp.pslverr)
    else $error("bus answer stalled or flagged an error");

  // Checked during reset itself, so no disable here
  reset_regs_a: assert property (@(posedge mclk)
    sys_rst |-> !s_q.done && !s_q.speed && !converter_on && channel_select == 4'h0 &&
      s_q.result == 10'h000 && apb_rsp.prdata == 32'h0)
    else $error("registers not all zero during reset");

  // Halt
  halt_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    halt_mode |=> !converter_on)
    else $error("halt left the converter on");

  halt_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    halt_mode |=> s_q.phase == ADCC_IDLE && !sample_hold)
    else $error("halt left the sequencer running");

  // Conversion length
  step_sample_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.phase == ADCC_SAMPLE |-> s_q.step < 4'h2)
    else $error("sample phase ran past two ticks");

  step_conv_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.phase == ADCC_CONVERT |-> s_q.step <= 4'h9)
    else $error("compare phase ran past ten steps");

  result_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(tick && s_q.phase == ADCC_CONVERT && s_q.step == 4'h9) |=> $stable(s_q.result))
    else $error("result changed before all ten bits were decided");

  dac_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.phase != ADCC_CONVERT |-> dac_code == 10'h000)
    else $error("trial code driven outside the compare phase");

  dac_trial_a: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.phase == ADCC_CONVERT |-> dac_code != 10'h000)
    else $error("no trial bit set during the compare phase");

  done_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(s_q.done));
  fast_c: cover property (@(posedge mclk) disable iff (sys_rst) s_q.speed && $rose(s_q.done));
  clear_c: cover property (@(posedge mclk) disable iff (sys_rst) s_q.done && rd_high);
  halt_c: cover property (@(posedge mclk) disable iff (sys_rst) halt_mode && converter_on);
  abort_c: cover property (@(posedge mclk) disable iff (sys_rst) wr_csr && s_q.phase == ADCC_CONVERT);

endmodule // adcc_ctrl

// ===== shared/adcc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are printed byte addresses that are not all multiples of four, so they are indices
package adcc_pkg;
  localparam logic [7:0] ADCC_IDX_CSR = 8'h70;
  localparam logic [7:0] ADCC_IDX_RESH = 8'h71;
  localparam logic [7:0] ADCC_IDX_RESL = 8'h72;
  localparam int ADCC_ADDR_W = 12;
  localparam logic [7:0] ADCC_CSR_RST = 8'h00;
  localparam logic [9:0] ADCC_RES_RST = 10'h000;
  localparam int ADCC_BIT_DONE = 7;
  localparam int ADCC_BIT_SPEED = 6;
  localparam int ADCC_BIT_ON = 5;
  localparam int ADCC_DIV_SLOW = 4;
  localparam int ADCC_DIV_FAST = 2;
  localparam int ADCC_SAMPLE_TICKS = 2;
  localparam int ADCC_RES_BITS = 10;
  localparam logic [3:0] ADCC_STEP_RST = 4'h0;
  localparam logic [1:0] ADCC_DIV_RST = 2'h0;

  typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_phase_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } adcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adcc_apb_rsp_t;

  typedef struct packed {
    logic done;
    logic speed;
    logic on;
    logic [3:0] chan;
    logic [9:0] result;
    logic [9:0] sar;
    adcc_phase_t phase;
    logic [3:0] step;
    logic [1:0] div;
    logic [31:0] prdata;
  } adcc_state_t;
endpackage

// ===== sim/adcc_analog_model.sv
// Purpose: Analog input mux and comparator in front of the converter control block
// Assumes: Each input holds a steady level built from its channel code
// Notes: Comparator answers combinationally, as the control block samples it on its own tick
`timescale 1ns/1ps
module adcc_analog_model (
  input wire logic [3:0] channel_select,
  input wire logic [9:0] dac_code,
  output logic cmp_above
);
  logic [9:0] level;
  // Distinct level per input so a wrong mux pick shows in the result
  assign level = {channel_select, 6'h2D};
  assign cmp_above = (level >= dac_code);
endmodule // adcc_analog_model

// ===== sim/tb.sv
// Purpose: Self-checking bench for the converter control registers
// Assumes: One-cycle APB answer; analog levels come from the mux model
// Notes: Conversion time is judged by polling, never by fixed waits
`timescale 1ns/1ps
module tb;
  import adcc_pkg::*;
  logic mclk, sys_rst, halt_mode, cmp_above, channel_reserved, converter_on, sample_hold;
  logic [3:0] channel_select;
  logic [9:0] dac_code;
  adcc_apb_req_t req;
  adcc_apb_rsp_t rsp;
  logic [31:0] rd;
  int error_cnt, num_checks, n_slow, n_fast;
  adcc_ctrl adcc_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .halt_mode(halt_mode),
    .cmp_above(cmp_above), .channel_select(channel_select), .channel_reserved(channel_reserved),
    .converter_on(converter_on), .sample_hold(sample_hold), .dac_code(dac_code));
  adcc_analog_model adcc_analog_model_i (.channel_select(channel_select), .dac_code(dac_code),
    .cmp_above(cmp_above));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Holds the request until pready is seen high, then takes read data at that edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{paddr: {2'b00, idx, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: {24'h0, wd}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    chk(32'(rsp.pslverr), 0);
    d = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic poll(output int n);
    n = 0;
    rd = 0;
    while (rd[7] !== 1'b1 && n < 300) begin
      apb(1'b0, ADCC_IDX_CSR, 8'h00, rd);
      n++;
    end
    chk(rd[7], 1);
  endtask
  task automatic t_reset;
    apb(1'b1, ADCC_IDX_RESL, 8'hFF, rd);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(ADCC_IDX_CSR + i), 8'h00, rd);
      chk(rd, 0);
    end
    $display("reset test done");
  endtask
  // Channel switch mid-conversion, then a result read pair and continuous restart
  task automatic t_conv(input logic sp, input logic [3:0] ch, output int n);
    logic [9:0] r;
    int m;
    r = {ch, 6'h2D};
    apb(1'b1, ADCC_IDX_CSR, {1'b0, sp, 2'b10, ch ^ 4'h4}, rd);
    repeat (10) @(posedge mclk);
    apb(1'b1, ADCC_IDX_CSR, {1'b0, sp, 2'b10, ch}, rd);
    poll(n);
    apb(1'b0, ADCC_IDX_RESL, 8'h00, rd);
    chk(rd, {30'h0, r[1:0]});
    apb(1'b0, ADCC_IDX_RESH, 8'h00, rd);
    chk(rd, {24'h0, r[9:2]});
    apb(1'b0, ADCC_IDX_CSR, 8'h00, rd);
    chk(rd, {24'h0, 1'b0, sp, 2'b10, ch});
    poll(m);
    apb(1'b1, ADCC_IDX_CSR, {1'b0, sp, 2'b10, ch}, rd);
    apb(1'b0, ADCC_IDX_CSR, 8'h00, rd);
    chk(rd[7], 0);
    $display("conversion test done speed=%0d", sp);
  endtask
  task automatic t_chan;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, ADCC_IDX_CSR, 8'(i), rd);
      // The write lands at the edge the task returns on; look once it has settled
      @(negedge mclk);
      chk(channel_reserved, 32'(i == 6 || i == 7 || i == 9 || i == 11));
      chk(channel_select, i[3:0]);
    end
    $display("channel test done");
  endtask
  task automatic t_halt;
    apb(1'b1, ADCC_IDX_CSR, 8'h20, rd);
    halt_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(converter_on, 0);
    chk(sample_hold, 0);
    chk(dac_code, 0);
    halt_mode <= 1'b0;
    apb(1'b1, ADCC_IDX_CSR, 8'h00, rd);
    repeat (120) @(posedge mclk);
    apb(1'b0, ADCC_IDX_CSR, 8'h00, rd);
    chk(rd, 0);
    $display("halt test done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    halt_mode = 1'b0;
    req = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_conv(1'b0, 4'h3, n_slow);
    t_conv(1'b1, 4'hC, n_fast);
    chk(32'(n_fast < n_slow), 1);
    t_chan();
    t_halt();
    wrap_up();
  end
endmodule // tb
